// [core/vr_seq_pkg.sv]
// Constants, state codes and trip-level codes for the regulator supervisor.
// Assumes a 10 MHz system clock; the reference stepping cycle counts below are derived from that rate.
package vr_seq_pkg;

  // System clock
  localparam int CLK_HZ          = 10_000_000;

  // Reference stepping times, in microseconds
  localparam int VID_STEP_US     = 4;
  localparam int RAMP_STEP_US    = 32;
  localparam int VID_STEP_CYC    = (VID_STEP_US * CLK_HZ) / 1_000_000;
  localparam int VID_HALF_CYC    = VID_STEP_CYC / 2;
  localparam int RAMP_STEP_CYC   = (RAMP_STEP_US * CLK_HZ) / 1_000_000;

  localparam int TMR_W           = 9;
  localparam logic [TMR_W-1:0] STEP_LAST = TMR_W'(VID_STEP_CYC - 1);
  localparam logic [TMR_W-1:0] HALF_LAST = TMR_W'(VID_HALF_CYC - 1);
  localparam logic [TMR_W-1:0] RAMP_LAST = TMR_W'(RAMP_STEP_CYC - 1);

  // Identification code and reference, reference in 12.5 mV steps from zero
  localparam int VID_W           = 6;
  localparam int REF_W           = 7;
  localparam logic [VID_W-1:0] VID_NO_LOAD = 6'h3F;
  localparam logic [VID_W-1:0] VID_RESET   = 6'h3F;
  localparam logic [REF_W-1:0] VID_BASE    = 7'h2A;   // 0.525 V in steps
  localparam logic [REF_W-1:0] REF_ZERO    = 7'h00;
  localparam logic [REF_W-1:0] REF_ONE     = 7'h01;

  // No-load code delay, clock cycles
  localparam logic [1:0] OFF_DELAY_LAST = 2'h1;

  // Switching-cycle counts
  localparam int SW_W            = 12;
  localparam logic [SW_W-1:0] SS_DELAY_LAST = SW_W'(64 - 1);
  localparam logic [SW_W-1:0] OC_HOLD_LAST  = SW_W'(4096 - 1);
  localparam int OFS_W           = 10;
  localparam logic [OFS_W-1:0] OFFSET_SW    = OFS_W'(640);
  localparam int NUM_CH          = 4;
  localparam int CH_CNT_W        = 4;
  localparam logic [CH_CNT_W-1:0] CH_OC_SW  = CH_CNT_W'(8);

  // Comparator bundle layout for the synchroniser
  localparam int SYNC_W          = 10 + NUM_CH + VID_W;

  // Supervisor states, one-hot
  typedef enum logic [5:0] {
    ST_SHUT   = 6'b00_0001,
    ST_SS_DLY = 6'b00_0010,
    ST_SS_RMP = 6'b00_0100,
    ST_RUN    = 6'b00_1000,
    ST_OC_WT  = 6'b01_0000,
    ST_OV_HLT = 6'b10_0000
  } sup_state_t;

  // Overvoltage trip level selection handed to the analog comparator
  typedef enum logic [2:0] {
    TRIP_PRE_EN   = 3'h0,   // 1.7 V fixed
    TRIP_NO_LOAD  = 3'h1,   // shutdown level
    TRIP_SS_MAX   = 3'h2,   // higher of 1.5 V or ref + 200 mV
    TRIP_RUN_REF  = 3'h3,   // ref + 200 mV
    TRIP_AFTER_OV = 3'h4    // ref + 200 mV after an overvoltage disable
  } trip_sel_t;

endpackage

// [core/sync_bank.sv]
// Two-flop synchroniser bank for asynchronous comparator and pin levels.
// Assumes each bit is an independent level; multi-bit words must be qualified downstream.
`timescale 1ns/1ps
module sync_bank #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,  // System clock
  input  wire logic         resetn_i,   // Async reset, active low
  input  wire logic [W-1:0] async_i,    // Raw levels
  output logic      [W-1:0] sync_o      // Synchronised levels
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// [core/ref_stepper.sv]
// Internal reference stepper: soft-start ramp and on-the-fly code tracking.
// Assumes target_i is a settled code and change_i a one-cycle pulse per accepted change.
`timescale 1ns/1ps
module ref_stepper
  import vr_seq_pkg::*;
(
  input  wire logic                         clk_sys_i,  // System clock
  input  wire logic                         resetn_i,   // Async reset, active low
  input  wire logic                         clear_i,    // Force reference to zero
  input  wire logic                         ramp_i,     // Soft-start ramp mode
  input  wire logic                         run_i,      // Tracking mode
  input  wire logic                         change_i,   // New code accepted
  input  wire logic [vr_seq_pkg::REF_W-1:0] target_i,   // Requested level
  output logic      [vr_seq_pkg::REF_W-1:0] ref_o       // Reference level
);

  logic             wait_q;   // Half-cycle wait pending
  logic             slew_q;   // Multi-step slewing
  logic             up_q;     // Direction seen at change
  logic [TMR_W-1:0] tmr_q;
  logic             want_up;
  logic             differ;

  assign want_up = target_i > ref_o;
  assign differ  = target_i != ref_o;

  // Step sequencing; a sign reversal during the wait drops the step
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_o  <= REF_ZERO;
      wait_q <= 1'b0;
      slew_q <= 1'b0;
      up_q   <= 1'b0;
      tmr_q  <= '0;
    end else if (clear_i) begin
      ref_o  <= REF_ZERO;
      wait_q <= 1'b0;
      slew_q <= 1'b0;
      tmr_q  <= '0;
    end else if (ramp_i) begin
      wait_q <= 1'b0;
      slew_q <= 1'b0;
      if (tmr_q == RAMP_LAST) begin
        tmr_q <= '0;
        if (want_up) begin
          ref_o <= ref_o + REF_ONE;
        end
      end else begin
        tmr_q <= tmr_q + TMR_W'(1);
      end
    end else if (run_i) begin
      if (change_i) begin
        wait_q <= 1'b1;
        slew_q <= 1'b0;
        up_q   <= want_up;
        tmr_q  <= '0;
      end else if (wait_q) begin
        if (tmr_q == HALF_LAST) begin
          wait_q <= 1'b0;
          tmr_q  <= '0;
          if (differ && (want_up == up_q)) begin
            ref_o  <= up_q ? ref_o + REF_ONE : ref_o - REF_ONE;
            slew_q <= 1'b1;
          end
        end else begin
          tmr_q <= tmr_q + TMR_W'(1);
        end
      end else if (slew_q) begin
        if (!differ) begin
          slew_q <= 1'b0;
          tmr_q  <= '0;
        end else if (tmr_q == STEP_LAST) begin
          tmr_q <= '0;
          ref_o <= want_up ? ref_o + REF_ONE : ref_o - REF_ONE;
        end else begin
          tmr_q <= tmr_q + TMR_W'(1);
        end
      end
    end else begin
      // Hold level, e.g. during an overvoltage halt the trip tracks it
      wait_q <= 1'b0;
      slew_q <= 1'b0;
      tmr_q  <= '0;
    end
  end

endmodule

// [core/vr_sequence_fault_control.sv]
// Sequencing and fault supervisor of a multi-phase buck regulator controller.
// Assumes analog comparators, code table and modulator sit outside; sw_tick_i
// is a one-cycle pulse per switching cycle from logic on the same clock.
//
// Notes on behaviour
// - Code inputs must read equal on three clock edges before a change counts.
// - After a change, wait half a change cycle, then move reference one step.
// - Drop the pending step if the step direction reverses during that wait.
// - Larger differences step one level every change cycle until equal.
// - In shutdown every PWM output is held high-impedance; the code drives them low while an overvoltage pull-down is active.
// - Soft-start begins once supply, analog enable, logic enable and non-off code hold.
// - All-ones code: after two cycles pick shutdown trip level, disable PWM.
// - All-ones code or code cycling never clears a latched overvoltage halt.
// - Soft-start waits 64 switching cycles, then ramps reference linearly from zero.
// - PWM stays high-impedance in soft-start until reference reaches pre-bias level.
// - Sense offset applied at soft-start, ramped to zero over 640 switching cycles.
// - Power-good low in shutdown, high after soft-start, ignores overvoltage.
// - Undervoltage flag pulls power-good low whenever output is under threshold.
// - Trip level selection follows state: pre-enable, soft-start, run, after overvoltage.
// - Auxiliary overvoltage trip while supply is partly up is taken as a trip.
// - Overvoltage forces PWM low until sensed output falls under the low level.
// - Then PWM goes high-impedance at reference; each recurrence pulls low again.
// - Crowbar drive asserts together with the overvoltage pull-down.
// - Overvoltage halts PWM until enable, logic enable or supply reset.
// - Mean current above reference trips overcurrent shutdown at once.
// - Any channel over reference for eight switching cycles trips overcurrent.
// - Overcurrent: PWM high-impedance, hold 4096 switching cycles, retry if enabled.
`timescale 1ns/1ps
module vr_sequence_fault_control
  import vr_seq_pkg::*;
(
  input  wire logic                         clk_sys_i,              // System clock, 10 MHz
  input  wire logic                         resetn_i,               // Async reset, active low
  input  wire logic                         sw_tick_i,              // Switching cycle pulse
  input  wire logic [vr_seq_pkg::VID_W-1:0] voltage_id_code_i,      // Processor code pins
  input  wire logic                         por_ok_i,               // Supply above reset level
  input  wire logic                         enable_above_thr_i,     // Analog enable above 1.29 V
  input  wire logic                         logic_enable_in_i,      // Logic enable pin
  input  wire logic                         undervolt_i,            // Output under 75 % of code
  input  wire logic                         overvolt_i,             // Output over selected trip
  input  wire logic                         overvolt_aux_i,         // Auxiliary trip, partial supply
  input  wire logic                         sensed_output_low_i,    // Output under release level
  input  wire logic                         diff_sense_at_ref_i,    // Diff sense down to reference
  input  wire logic                         prebias_reached_i,      // Reference at pre-bias output
  input  wire logic                         mean_channel_current_i, // Mean current over reference
  input  wire logic [vr_seq_pkg::NUM_CH-1:0] chan_over_i,           // Channel current over ref
  output logic                              pwm_hiz_o,              // PWM outputs three-stated
  output logic                              pwm_force_low_o,        // PWM outputs driven low
  output logic                              supply_ok_flag_o,       // Power-good
  output logic                              crowbar_drive_out_o,    // Crowbar gate drive
  output vr_seq_pkg::trip_sel_t             ov_trip_sel_o,          // Trip level selection
  output logic      [vr_seq_pkg::REF_W-1:0] ref_level_o,            // Reference, 12.5 mV steps
  output logic      [vr_seq_pkg::OFS_W-1:0] sense_offset_o,         // Offset, 640 = 100 mV
  output logic                              undervolt_flag_o,       // Undervoltage seen
  output logic                              oc_fault_o,             // Overcurrent hold active
  output logic                              ov_halted_o             // Overvoltage latch
);

  // Synchronised levels
  logic [SYNC_W-1:0] raw_all;
  logic [SYNC_W-1:0] sync_all;
  logic [VID_W-1:0]  vid_s;
  logic [NUM_CH-1:0] chan_s;
  logic por_s, en_s, ll_s, uv_s, ov_s, ova_s, vlow_s, dref_s, preb_s, mean_s;

  assign raw_all = {voltage_id_code_i, chan_over_i, por_ok_i, enable_above_thr_i,
                    logic_enable_in_i, undervolt_i, overvolt_i, overvolt_aux_i,
                    sensed_output_low_i, diff_sense_at_ref_i, prebias_reached_i,
                    mean_channel_current_i};

  // Comparators are asynchronous to the clock
  sync_bank #(.W(SYNC_W)) u_sync (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .async_i   (raw_all),
    .sync_o    (sync_all)
  );

  assign {vid_s, chan_s, por_s, en_s, ll_s, uv_s, ov_s, ova_s,
          vlow_s, dref_s, preb_s, mean_s} = sync_all;

  // Code qualification: three equal samples before acceptance
  logic [VID_W-1:0] vid_p1_q;
  logic [VID_W-1:0] vid_p2_q;
  logic [VID_W-1:0] vid_q;
  logic             vid_chg_q;
  logic             vid_stable;

  assign vid_stable = (vid_s == vid_p1_q) && (vid_p1_q == vid_p2_q);

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vid_p1_q  <= VID_RESET;
      vid_p2_q  <= VID_RESET;
      vid_q     <= VID_RESET;
      vid_chg_q <= 1'b0;
    end else begin
      vid_p1_q  <= vid_s;
      vid_p2_q  <= vid_p1_q;
      vid_chg_q <= vid_stable && (vid_s != vid_q);
      if (vid_stable) begin
        vid_q <= vid_s;
      end
    end
  end

  // No-load code takes effect only after a short delay
  logic [1:0] off_cnt_q;
  logic       vid_off_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      off_cnt_q <= '0;
      vid_off_q <= 1'b1;
    end else if (vid_q != VID_NO_LOAD) begin
      off_cnt_q <= '0;
      vid_off_q <= 1'b0;
    end else if (off_cnt_q == OFF_DELAY_LAST) begin
      vid_off_q <= 1'b1;
    end else begin
      off_cnt_q <= off_cnt_q + 2'h1;
    end
  end

  // Enable qualification; the code is deliberately absent from hw_reset
  logic enable_ok;
  logic hw_reset;

  assign enable_ok = por_s && en_s && ll_s && !vid_off_q;
  assign hw_reset  = !por_s || !en_s || !ll_s;

  // Overvoltage onset, auxiliary path included
  logic ov_any;
  logic ov_prev_q;
  logic ov_rise;

  assign ov_any  = ov_s || ova_s;
  assign ov_rise = ov_any && !ov_prev_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ov_prev_q <= 1'b0;
    end else begin
      ov_prev_q <= ov_any;
    end
  end

  // Per-channel sustained overcurrent counters
  logic [NUM_CH-1:0] ch_trip;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      logic [CH_CNT_W-1:0] cnt_q;
      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cnt_q <= '0;
        end else if (!chan_s[gi]) begin
          cnt_q <= '0;
        end else if (sw_tick_i && (cnt_q != CH_OC_SW)) begin
          cnt_q <= cnt_q + CH_CNT_W'(1);
        end
      end
      assign ch_trip[gi] = (cnt_q == CH_OC_SW);
    end
  endgenerate

  logic oc_trip;

  assign oc_trip = mean_s || (|ch_trip);

  // Supervisor state machine
  sup_state_t       state_q;
  sup_state_t       state_d;
  logic [SW_W-1:0]  sw_cnt_q;
  logic             at_target;
  logic [REF_W-1:0] target;
  logic [REF_W-1:0] ref_lvl;

  assign target    = VID_BASE + REF_W'(vid_q);
  assign at_target = (ref_lvl == target);

  always_comb begin
    state_d = state_q;
    if (ov_rise && (state_q != ST_OV_HLT)) begin
      state_d = ST_OV_HLT;
    end else begin
      case (state_q)
        ST_SHUT: begin
          if (enable_ok) begin
            state_d = ST_SS_DLY;
          end
        end
        ST_SS_DLY: begin
          if (!enable_ok) begin
            state_d = ST_SHUT;
          end else if (oc_trip) begin
            state_d = ST_OC_WT;
          end else if (sw_tick_i && (sw_cnt_q == SS_DELAY_LAST)) begin
            state_d = ST_SS_RMP;
          end
        end
        ST_SS_RMP: begin
          if (!enable_ok) begin
            state_d = ST_SHUT;
          end else if (oc_trip) begin
            state_d = ST_OC_WT;
          end else if (at_target) begin
            state_d = ST_RUN;
          end
        end
        ST_RUN: begin
          if (!enable_ok) begin
            state_d = ST_SHUT;
          end else if (oc_trip) begin
            state_d = ST_OC_WT;
          end
        end
        ST_OC_WT: begin
          if (sw_tick_i && (sw_cnt_q == OC_HOLD_LAST)) begin
            state_d = enable_ok ? ST_SS_DLY : ST_SHUT;
          end
        end
        ST_OV_HLT: begin
          if (hw_reset) begin
            state_d = ST_SHUT;
          end
        end
        default: begin
          state_d = ST_SHUT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_SHUT;
    end else begin
      state_q <= state_d;
    end
  end

  // Switching-cycle counter restarts on every state change
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sw_cnt_q <= '0;
    end else if (state_d != state_q) begin
      sw_cnt_q <= '0;
    end else if (sw_tick_i) begin
      sw_cnt_q <= sw_cnt_q + SW_W'(1);
    end
  end

  // Reference generation
  logic ref_clear;

  assign ref_clear = (state_q == ST_SHUT) || (state_q == ST_SS_DLY) || (state_q == ST_OC_WT);

  ref_stepper u_ref (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .clear_i   (ref_clear),
    .ramp_i    (state_q == ST_SS_RMP),
    .run_i     (state_q == ST_RUN),
    .change_i  (vid_chg_q),
    .target_i  (target),
    .ref_o     (ref_lvl)
  );

  assign ref_level_o = ref_lvl;

  // Pre-bias hold-off: no switching until the ramp meets the output
  logic prebias_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prebias_q <= 1'b0;
    end else if (state_q != ST_SS_RMP && state_q != ST_RUN) begin
      prebias_q <= 1'b0;
    end else if (preb_s) begin
      prebias_q <= 1'b1;
    end
  end

  // Sense offset, held through the delay and ramped by switching cycles
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sense_offset_o <= '0;
    end else if (state_d == ST_SS_DLY) begin
      sense_offset_o <= OFFSET_SW;
    end else if (state_d == ST_SS_RMP || state_d == ST_RUN) begin
      if (sw_tick_i && (sense_offset_o != '0)) begin
        sense_offset_o <= sense_offset_o - OFS_W'(1);
      end
    end else begin
      sense_offset_o <= '0;
    end
  end

  // Overvoltage pull-down; one clock of latency is the fastest a flop gives
  logic force_low_d;

  assign force_low_d = ov_rise || (pwm_force_low_o && !(vlow_s && dref_s));

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwm_force_low_o     <= 1'b0;
      crowbar_drive_out_o <= 1'b0;
    end else begin
      pwm_force_low_o     <= force_low_d;
      crowbar_drive_out_o <= force_low_d;
    end
  end

  // PWM three-state whenever not switching and not pulled low
  logic switching;

  assign switching = (state_d == ST_RUN) || (state_d == ST_SS_RMP && (prebias_q || preb_s));

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwm_hiz_o <= 1'b1;
    end else begin
      pwm_hiz_o <= !force_low_d && !switching;
    end
  end

  // Power-good, kept through an overvoltage halt
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      supply_ok_flag_o <= 1'b0;
    end else if (state_d == ST_OV_HLT) begin
      supply_ok_flag_o <= supply_ok_flag_o && !uv_s;
    end else begin
      supply_ok_flag_o <= (state_d == ST_RUN) && !uv_s;
    end
  end

  // Trip level selection and status
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ov_trip_sel_o    <= TRIP_PRE_EN;
      undervolt_flag_o <= 1'b0;
      oc_fault_o       <= 1'b0;
      ov_halted_o      <= 1'b0;
    end else begin
      undervolt_flag_o <= uv_s;
      oc_fault_o       <= (state_d == ST_OC_WT);
      ov_halted_o      <= (state_d == ST_OV_HLT);
      case (state_d)
        ST_OV_HLT: ov_trip_sel_o <= TRIP_AFTER_OV;
        ST_RUN:    ov_trip_sel_o <= TRIP_RUN_REF;
        ST_SHUT:   ov_trip_sel_o <= vid_off_q ? TRIP_NO_LOAD : TRIP_PRE_EN;
        default:   ov_trip_sel_o <= TRIP_SS_MAX;
      endcase
    end
  end

endmodule

// [tb/vr_seq_chk.sv]
// Port checker for the regulator supervisor.
// Assumes one clock domain; bound to the top module at the foot.
`timescale 1ns/1ps
module vr_seq_chk
  import vr_seq_pkg::*;
(
  input wire logic clk_sys_i, resetn_i, overvolt_i,        // Clock, reset, trip
  input wire logic por_ok_i, enable_above_thr_i,           // Supply, enable
  input wire logic logic_enable_in_i, pwm_hiz_o,           // Enable, PWM off
  input wire logic pwm_force_low_o, crowbar_drive_out_o,   // OV actions
  input wire logic ov_halted_o, supply_ok_flag_o,          // Latch, good
  input wire logic undervolt_flag_o,                       // UV flag
  input wire vr_seq_pkg::trip_sel_t ov_trip_sel_o,         // Trip level
  input wire logic [vr_seq_pkg::REF_W-1:0] ref_level_o     // Reference
);
  logic [2:0] en_cnt_q;
  // Cycles with all enables high; a halt may only end after a drop
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) en_cnt_q <= 3'h0;
    else if (!(por_ok_i && enable_above_thr_i && logic_enable_in_i)) en_cnt_q <= 3'h0;
    else if (en_cnt_q != 3'h7) en_cnt_q <= en_cnt_q + 3'h1;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // A reference move other than a clear to zero
  sequence s_step;
    ref_level_o != $past(ref_level_o) && ref_level_o != 7'h00;
  endsequence
  sequence s_calm;
    (ref_level_o == 7'h00 || $stable(ref_level_o)) [*8];
  endsequence
  chk_ov_onset: assert property ($rose(overvolt_i) |-> ##[1:5] pwm_force_low_o)
    else $error("no pull-down after trip");
  chk_crowbar_pair: assert property ($rose(crowbar_drive_out_o) |-> pwm_force_low_o)
    else $error("crowbar without pull-down");
  chk_pwm_excl: assert property (!(pwm_hiz_o && pwm_force_low_o))
    else $error("PWM both off and low");
  chk_uv_good: assert property (undervolt_flag_o && $past(undervolt_flag_o) |-> !supply_ok_flag_o)
    else $error("good high in undervoltage");
  chk_noload_off: assert property (ov_trip_sel_o == TRIP_NO_LOAD |-> pwm_hiz_o)
    else $error("PWM active at no-load");
  chk_halt_hold: assert property ($fell(ov_halted_o) |-> en_cnt_q < 3'h6)
    else $error("halt left while enabled");
  chk_ref_unit: assert property (s_step |->
    ref_level_o - $past(ref_level_o) == 1 || $past(ref_level_o) - ref_level_o == 1)
    else $error("reference moved more than one step");
  chk_ref_pace: assert property (s_step |=> s_calm)
    else $error("reference steps too close");
endmodule
bind vr_sequence_fault_control vr_seq_chk u_chk (.*);

// [tb/cpu_vid_model.sv]
// Processor side: drives the code pins from the code it wants.
// Assumes the bench holds each requested code, of any step size, until the next request.
`timescale 1ns/1ps
module cpu_vid_model (
  input  wire logic [vr_seq_pkg::VID_W-1:0] want_i,    // Requested code
  input  wire logic                         clk_sys_i, // System clock
  output logic      [vr_seq_pkg::VID_W-1:0] pins_o     // Code pins
);
  // Pins start at no-load and change just after an edge
  initial pins_o = 6'h3F;
  always @(posedge clk_sys_i) pins_o <= want_i;
endmodule

// [tb/vr_sequence_fault_control_tb.sv]
// Self-checking bench for the regulator supervisor.
// Assumes the checker binds itself; comparator levels are driven here.
`timescale 1ns/1ps
module vr_sequence_fault_control_tb;
  import vr_seq_pkg::*;
  logic clk_sys_i = 0, resetn_i = 0, tick = 0, por = 0, en = 0, le = 0, uv = 0, ov = 0;
  logic slow = 0, dref = 0, pb = 0, mean = 0, ova = 0, hiz, flow, pg, cb, uvf, oc, halt;
  logic [3:0] ch = 4'h0;
  logic [5:0] want = 6'h3F, pins;
  logic [6:0] ref_l;
  logic [9:0] ofs;
  trip_sel_t trip;
  int error_cnt = 0, total_checks = 0, c, k, n, ph = 0;
  // Clock, switching tick every four clocks, pre-bias seen at step 20
  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    ph <= (ph + 1) % 4;
    tick <= (ph == 0);
    pb <= (ref_l >= 7'h14);
  end
  cpu_vid_model PROC (.clk_sys_i(clk_sys_i), .want_i(want), .pins_o(pins));
  vr_sequence_fault_control DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sw_tick_i(tick),
    .voltage_id_code_i(pins), .por_ok_i(por), .enable_above_thr_i(en), .logic_enable_in_i(le),
    .undervolt_i(uv), .overvolt_i(ov), .overvolt_aux_i(ova), .sensed_output_low_i(slow),
    .diff_sense_at_ref_i(dref), .prebias_reached_i(pb), .mean_channel_current_i(mean),
    .chan_over_i(ch), .pwm_hiz_o(hiz), .pwm_force_low_o(flow), .supply_ok_flag_o(pg),
    .crowbar_drive_out_o(cb), .ov_trip_sel_o(trip), .ref_level_o(ref_l),
    .sense_offset_o(ofs), .undervolt_flag_o(uvf), .oc_fault_o(oc), .ov_halted_o(halt));
  task automatic chk(string s, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", s, exp, seen);
    end
  endtask
  task automatic wt(int m);
    repeat (m) @(posedge clk_sys_i);
  endtask
  task automatic tk(int m);
    repeat (m) @(posedge clk_sys_i iff tick);
  endtask
  task automatic test_done;
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog: the run needs about 35k clocks, limit at 90k
  initial begin
    #9_000_000;
    error_cnt++;
    test_done;
  end
  // Main sequence; expected reference is code plus the 0.525 V base
  initial begin
    void'($urandom(32'hbdd7_e9b2));
    c = $urandom % 8;
    k = $urandom % 4;
    wt(12);
    resetn_i <= 1'b1;
    wt(2);
    chk("reset", {hiz, pg, ref_l, trip}, {2'b10, 7'h00, TRIP_NO_LOAD});
    want <= 6'(c);
    wt(8);
    {por, en, le} <= 3'b111;
    wt(10);
    chk("ss", {ofs, trip, hiz}, {OFFSET_SW, TRIP_SS_MAX, 1'b1});
    tk(60);
    chk("delay", {ref_l, hiz}, {7'h00, 1'b1});
    for (n = 0; n < 20000 && ref_l !== 7'(42 + c); n++) wt(1);
    chk("ramp", n >= (41 + c) * 320 && n <= (43 + c) * 320, 1);
    wt(8);
    chk("run", {hiz, pg, trip, ofs}, {2'b01, TRIP_RUN_REF, 10'h000});
    $display("start-up done");
    want <= 6'(c + 2);
    wt(45);
    chk("step1", ref_l, 7'(43 + c));
    wt(55);
    chk("step2", ref_l, 7'(44 + c));
    // Up request withdrawn by a down request inside the half-cycle wait
    want <= 6'(c + 3);
    wt(8);
    want <= 6'(c + 1);
    wt(22);
    chk("reverse", ref_l, 7'(44 + c));
    wt(20);
    chk("step down", ref_l, 7'(43 + c));
    uv <= 1'b1;
    wt(8);
    chk("uv", {uvf, pg}, 2'b10);
    uv <= 1'b0;
    wt(8);
    chk("uv end", {uvf, pg}, 2'b01);
    $display("tracking done");
    ov <= 1'b1;
    wt(6);
    chk("ov", {flow, cb, pg, halt}, 4'hF);
    {ov, slow, dref} <= 3'b011;
    wt(6);
    chk("ov release", {hiz, flow}, 2'b10);
    {ov, slow, dref} <= 3'b100;
    wt(6);
    chk("ov again", flow, 1);
    {ov, slow, dref} <= 3'b011;
    want <= 6'h3F;
    wt(12);
    chk("ov latch", {halt, trip}, {1'b1, TRIP_AFTER_OV});
    le <= 1'b0;
    wt(10);
    chk("ov exit", {halt, pg}, 2'b00);
    $display("overvoltage done");
    want <= 6'(c);
    wt(8);
    // Auxiliary trip while disabled: pull-down and crowbar, then back to shutdown
    {ova, slow, dref} <= 3'b100;
    wt(6);
    chk("aux ov", {flow, cb, trip}, {2'b11, TRIP_PRE_EN});
    {ova, slow, dref} <= 3'b011;
    wt(6);
    le <= 1'b1;
    wt(10);
    mean <= 1'b1;
    wt(6);
    chk("mean oc", {oc, hiz}, 2'b11);
    mean <= 1'b0;
    for (n = 0; n < 5000 && oc === 1'b1; n += tick) wt(1);
    chk("hold", n >= 4090 && n <= 4098, 1);
    wt(4);
    chk("retry", ofs, OFFSET_SW);
    want <= 6'h3F;
    wt(10);
    chk("no load", {trip, hiz}, {TRIP_NO_LOAD, 1'b1});
    want <= 6'(c);
    wt(12);
    chk("restart", ofs, OFFSET_SW);
    ch[k] <= 1'b1;
    tk(5);
    ch[k] <= 1'b0;
    tk(1);
    ch[k] <= 1'b1;
    tk(5);
    chk("chan short", oc, 0);
    tk(5);
    chk("chan long", oc, 1);
    $display("overcurrent done");
    test_done;
  end
endmodule
